// ---- rtl/eeprom_cmd.sv ----
// command logic of a 3-wire serial eeprom: word and array write/erase,
// program enable/disable, supply-low lockout and clock-count monitor
// assumes all serial pins and the supply detector are asynchronous
`timescale 1ns/10ps

// How it works
// [RULE1] word write programs at chip select fall
// [RULE2] writes program data without prior erase
// [RULE3] wrong clock count cancels write commands
// [RULE4] word erase sets all sixteen bits
// [RULE5] erase has no data, starts at fall
// [RULE6] array write copies word to all addresses
// [RULE7] array erase sets whole array to ones
// [RULE8] enable command allows array changes
// [RULE9] disable command blocks array changes
// [RULE10] mode changes at chip select fall
// [RULE11] power-on or low supply disables, cancels
// [RULE12] host re-enables after supply dip
// [RULE13] host disables when not writing
// [RULE14] no programming starts while select high
// [RULE15] data out is a three-state driver
// [RULE16] disabled mode completes frame, no change
// [RULE17] programming ends within 8 ms, inputs ignored
// [RULE18] busy low, ready high on data out
// [RULE19] start bit is first clock with data high
// [RULE20] cancelled command leaves device ready
module eeprom_cmd #(
  parameter int PROG_CYCLES = eeprom_cmd_pkg::PROG_CYCLES
) (
  // core clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // serial pins
  input  wire logic        chip_select,
  input  wire logic        serial_clock,
  input  wire logic        serial_data_in,
  output logic             data_out,
  output logic             data_out_oe,
  // supply detector, high while supply is too low
  input  wire logic        supply_low,
  // status and array observation
  output logic             program_enabled,
  output logic             busy,
  input  wire logic [5:0]  peek_addr,
  output logic      [15:0] peek_data
);

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] cs_sync_q, sclk_sync_q, sdin_sync_q, low_sync_q;
  logic       sclk_last_q;
  wire        cs_s   = cs_sync_q[1];
  wire        sclk_s = sclk_sync_q[1];
  wire        sdin_s = sdin_sync_q[1];
  wire        low_s  = low_sync_q[1];

  // two flops per pin, edge detect only on the second
  always_ff @(posedge clock) begin
    cs_sync_q   <= {cs_sync_q[0], chip_select};
    sclk_sync_q <= {sclk_sync_q[0], serial_clock};
    sdin_sync_q <= {sdin_sync_q[0], serial_data_in};
    low_sync_q  <= {low_sync_q[0], supply_low};
    sclk_last_q <= sclk_s;
  end

  wire sclk_rise = sclk_s & ~sclk_last_q;

  ////////////////////////////////////////////////////////////////////
  // state and datapath registers
  eeprom_cmd_pkg::state_t state_q, state_d;
  logic [4:0]                         cnt_q;
  logic [7:0]                         hdr_q;
  logic [15:0]                        shdata_q;
  logic [5:0]                         addr_q;
  logic [15:0]                        wdata_q;
  logic                               all_q;
  logic                               enabled_q;
  logic [eeprom_cmd_pkg::TIMER_W-1:0] timer_q;
  logic [15:0]                        mem_q [eeprom_cmd_pkg::WORDS];

  ////////////////////////////////////////////////////////////////////
  // command decode, valid at chip select fall in the shift state
  wire [4:0] hdr_sh   = 5'(eeprom_cmd_pkg::CNT_HDR - cnt_q);
  wire       hdr_full = cnt_q >= eeprom_cmd_pkg::CNT_HDR;
  wire [7:0] hdr_al   = hdr_full ? hdr_q : 8'(hdr_q << hdr_sh);
  wire [1:0] op       = hdr_al[7:6];
  wire [1:0] sub      = hdr_al[5:4];
  wire       cnt_word = cnt_q == eeprom_cmd_pkg::CNT_WORD;
  wire       cnt_hdr  = cnt_q == eeprom_cmd_pkg::CNT_HDR;
  wire       is_ext   = op == eeprom_cmd_pkg::OP_EXT;
  wire       op_wr    = op == eeprom_cmd_pkg::OP_WRITE;
  wire       op_er    = op == eeprom_cmd_pkg::OP_ERASE;
  wire       op_allw  = is_ext && sub == eeprom_cmd_pkg::SUB_ALLW;
  wire       op_alle  = is_ext && sub == eeprom_cmd_pkg::SUB_ALLE;
  // exact count only, over and under both cancel   see [RULE3]
  wire       cmd_wr   = op_wr && cnt_word;     // see [RULE1]
  wire       cmd_er   = op_er && cnt_hdr;      // see [RULE5]
  wire       cmd_allw = op_allw && cnt_word;   // see [RULE6]
  wire       cmd_alle = op_alle && cnt_hdr;    // see [RULE7]
  wire       cmd_any  = cmd_wr | cmd_er | cmd_allw | cmd_alle;
  wire       wr_class = op_wr | op_er | op_allw | op_alle;
  // address field is optional for the mode commands
  wire       mode_cnt = cnt_q >= eeprom_cmd_pkg::CNT_MODE_MIN && cnt_q <= eeprom_cmd_pkg::CNT_HDR;
  wire       cmd_on   = is_ext && sub == eeprom_cmd_pkg::SUB_ON && mode_cnt;
  wire       cmd_off  = is_ext && sub == eeprom_cmd_pkg::SUB_OFF && mode_cnt;
  wire       cs_fall  = state_q == eeprom_cmd_pkg::ST_SHIFT && !cs_s;
  // only a select fall with an exact, enabled command programs
  wire       prog_go  = cs_fall && cmd_any && enabled_q && !low_s; // see [RULE14] [RULE16]
  wire       commit   = state_q == eeprom_cmd_pkg::ST_PROG && timer_q == '0 && !low_s;
  wire       start    = cs_s && sclk_rise && sdin_s; // see [RULE19]
  wire       shifting = state_q == eeprom_cmd_pkg::ST_SHIFT && cs_s && sclk_rise;

  ////////////////////////////////////////////////////////////////////
  // sequencer; a cancelled command drops straight back to idle
  always_comb begin
    state_d = state_q;
    case (state_q)
      eeprom_cmd_pkg::ST_IDLE: begin
        if (cs_s) state_d = eeprom_cmd_pkg::ST_WAIT;
      end
      eeprom_cmd_pkg::ST_WAIT, eeprom_cmd_pkg::ST_READY: begin
        if (!cs_s) state_d = eeprom_cmd_pkg::ST_IDLE;
        else if (start) state_d = eeprom_cmd_pkg::ST_SHIFT; // see [RULE19]
      end
      eeprom_cmd_pkg::ST_SHIFT: begin
        if (!cs_s) begin
          state_d = prog_go ? eeprom_cmd_pkg::ST_PROG : eeprom_cmd_pkg::ST_IDLE; // see [RULE20]
        end
      end
      // serial pins are ignored until the timer runs out; low supply still aborts to idle
      eeprom_cmd_pkg::ST_PROG: begin
        if (timer_q == '0) state_d = eeprom_cmd_pkg::ST_READY; // see [RULE17]
      end
      default: state_d = eeprom_cmd_pkg::ST_IDLE;
    endcase
    if (low_s) state_d = eeprom_cmd_pkg::ST_IDLE; // see [RULE11]
  end

  always_ff @(posedge clock) begin
    if (reset) state_q <= eeprom_cmd_pkg::ST_IDLE;
    else state_q <= state_d;
  end

  ////////////////////////////////////////////////////////////////////
  // serial shifter: eight header bits, then the data word
  always_ff @(posedge clock) begin
    if (reset || state_d != eeprom_cmd_pkg::ST_SHIFT) begin
      cnt_q <= '0;
      hdr_q <= '0;
    end else if (shifting) begin
      if (cnt_q != eeprom_cmd_pkg::CNT_MAX) cnt_q <= cnt_q + 5'h01;
      if (!hdr_full) hdr_q <= {hdr_q[6:0], sdin_s};
    end
  end

  always_ff @(posedge clock) begin
    if (reset) shdata_q <= '0;
    else if (shifting && hdr_full) shdata_q <= {shdata_q[14:0], sdin_s};
  end

  ////////////////////////////////////////////////////////////////////
  // program mode; power-on and low supply force it off
  always_ff @(posedge clock) begin
    if (reset || low_s) enabled_q <= 1'b0;                // see [RULE11]
    else if (cs_fall && cmd_on) enabled_q <= 1'b1;        // see [RULE8] [RULE10]
    else if (cs_fall && cmd_off) enabled_q <= 1'b0;       // see [RULE9] [RULE10]
  end

  ////////////////////////////////////////////////////////////////////
  // latch the operation and run the programming timer
  always_ff @(posedge clock) begin
    if (reset) begin
      addr_q  <= '0;
      wdata_q <= '0;
      all_q   <= 1'b0;
      timer_q <= '0;
    end else if (prog_go) begin
      addr_q  <= hdr_al[5:0];
      // erase forces ones, write takes data as given   see [RULE2] [RULE4]
      wdata_q <= (cmd_er | cmd_alle) ? eeprom_cmd_pkg::ERASED_WORD : shdata_q;
      all_q   <= cmd_allw | cmd_alle;
      timer_q <= eeprom_cmd_pkg::TIMER_W'(PROG_CYCLES - 1); // see [RULE17]
    end else if (state_q == eeprom_cmd_pkg::ST_PROG && timer_q != '0) begin
      timer_q <= timer_q - 1'b1;
    end
  end

  // array cells are nonvolatile, so reset leaves them alone
  always_ff @(posedge clock) begin
    if (commit) begin
      if (all_q) begin
        for (int i = 0; i < eeprom_cmd_pkg::WORDS; i++) mem_q[i] <= wdata_q; // see [RULE6] [RULE7]
      end else begin
        mem_q[addr_q] <= wdata_q; // see [RULE1] [RULE4]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // data out: low while busy, high once ready, released on start bit
  wire in_prog  = state_q == eeprom_cmd_pkg::ST_PROG;
  wire in_ready = state_q == eeprom_cmd_pkg::ST_READY;
  wire oe_d     = cs_s && (in_prog || (in_ready && !start)); // see [RULE15] [RULE18]

  always_ff @(posedge clock) begin
    if (reset) begin
      data_out        <= 1'b0;
      data_out_oe     <= 1'b0;
      program_enabled <= 1'b0;
      busy            <= 1'b0;
      peek_data       <= '0;
    end else begin
      data_out        <= in_ready; // see [RULE18]
      data_out_oe     <= oe_d;
      program_enabled <= enabled_q;
      busy            <= in_prog;
      peek_data       <= mem_q[peek_addr];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  AST_COUNT_CANCEL: // see [RULE3]
    assert property (@(posedge clock) disable iff (reset)
      (cs_fall && wr_class && !cmd_any) |=> state_q == eeprom_cmd_pkg::ST_IDLE)
    else $error("miscounted write command was not cancelled");

  AST_DISABLED_NO_PROG: // see [RULE16]
    assert property (@(posedge clock) disable iff (reset)
      (cs_fall && !enabled_q) |=> !busy ##1 !busy)
    else $error("programming started in disabled mode");

  AST_PROG_ON_FALL: // see [RULE14]
    assert property (@(posedge clock) disable iff (reset)
      (state_q == eeprom_cmd_pkg::ST_PROG && $past(state_q) != eeprom_cmd_pkg::ST_PROG)
        |-> $past(cs_sync_q[1], 1) == 1'b0 && $past(cmd_any) && $past(enabled_q))
    else $error("programming began without a valid select fall");

  AST_BUSY_LOW: // see [RULE18]
    assert property (@(posedge clock) disable iff (reset)
      (in_prog && cs_s) |=> data_out_oe && !data_out)
    else $error("data out not low while busy");

  AST_READY_HIGH: // see [RULE18]
    assert property (@(posedge clock) disable iff (reset)
      (in_ready && cs_s && !start) |=> data_out_oe && data_out)
    else $error("data out not high once ready");

  AST_ENABLE_CMD: // see [RULE8]
    assert property (@(posedge clock) disable iff (reset)
      (cs_fall && cmd_on && !low_s) |=> enabled_q ##1 program_enabled)
    else $error("enable command did not take effect");

  AST_LOW_DISABLES: // see [RULE11]
    assert property (@(posedge clock) disable iff (reset)
      low_s |=> !enabled_q && state_q == eeprom_cmd_pkg::ST_IDLE)
    else $error("low supply left device enabled or active");

  AST_PROG_ENDS: // see [RULE17]
    assert property (@(posedge clock) disable iff (reset)
      (in_prog && timer_q == '0) |=> !in_prog)
    else $error("programming did not end at timer expiry");

  AST_DUMMY_CLOCK: // see [RULE19]
    assert property (@(posedge clock) disable iff (reset)
      (state_q == eeprom_cmd_pkg::ST_WAIT && cs_s && sclk_rise && !sdin_s && !low_s)
        |=> state_q == eeprom_cmd_pkg::ST_WAIT)
    else $error("dummy clock taken as start bit");

  AST_WORD_WRITTEN: // see [RULE1]
    assert property (@(posedge clock) disable iff (reset)
      (commit && !all_q) |=> mem_q[$past(addr_q)] == $past(wdata_q))
    else $error("word not programmed with latched data");

  AST_ARRAY_WRITTEN: // see [RULE6]
    assert property (@(posedge clock) disable iff (reset)
      (commit && all_q) |=> mem_q[0] == $past(wdata_q) && mem_q[63] == $past(wdata_q))
    else $error("array not filled");

  AST_WRITE_DATA: // see [RULE2]
    assert property (@(posedge clock) disable iff (reset)
      (prog_go && (cmd_wr || cmd_allw)) |=> wdata_q == $past(shdata_q))
    else $error("write did not latch the shifted data word");

  AST_ERASE_ONES: // see [RULE4]
    assert property (@(posedge clock) disable iff (reset)
      (prog_go && (cmd_er || cmd_alle)) |=> wdata_q == eeprom_cmd_pkg::ERASED_WORD)
    else $error("erase did not load the all-ones word");

  AST_DISABLE_CMD: // see [RULE9]
    assert property (@(posedge clock) disable iff (reset)
      (cs_fall && cmd_off) |=> !enabled_q ##1 !program_enabled)
    else $error("disable command did not take effect");

  AST_MODE_HOLDS: // see [RULE10]
    assert property (@(posedge clock) disable iff (reset)
      (!cs_fall && !low_s) |=> $stable(enabled_q))
    else $error("program mode changed without a select fall");

  AST_CANCEL_READY: // see [RULE20]
    assert property (@(posedge clock) disable iff (reset)
      (cs_fall && !prog_go) |=> state_q == eeprom_cmd_pkg::ST_IDLE ##1 !busy)
    else $error("cancelled command entered the busy period");

  AST_OE_DESELECT: // see [RULE15]
    assert property (@(posedge clock) disable iff (reset)
      !cs_s |=> !data_out_oe)
    else $error("data out driven while deselected");

endmodule : eeprom_cmd

// ---- rtl/eeprom_cmd_pkg.sv ----
// constants for the serial eeprom write command block
// assumes a 250 MHz core clock that oversamples the serial pins
package eeprom_cmd_pkg;
  // array shape
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int WORDS  = 64;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  // serial clocks after the start bit for each command
  localparam logic [4:0] CNT_HDR      = 5'h08;
  localparam logic [4:0] CNT_WORD     = 5'h18;
  localparam logic [4:0] CNT_MODE_MIN = 5'h04;
  localparam logic [4:0] CNT_MAX      = 5'h1F;

  // opcode and sub-opcode codes
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] OP_EXT   = 2'h0;
  localparam logic [1:0] SUB_OFF  = 2'h0;
  localparam logic [1:0] SUB_ALLW = 2'h1;
  localparam logic [1:0] SUB_ALLE = 2'h2;
  localparam logic [1:0] SUB_ON   = 2'h3;

  // programming time
  localparam int CLOCK_PERIOD_NS = 4;
  localparam int PROG_TIME_NS    = 8_000_000;
  localparam int PROG_CYCLES     = PROG_TIME_NS / CLOCK_PERIOD_NS;
  localparam int TIMER_W         = 21;

  // command sequencer states
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_WAIT  = 5'h02,
    ST_SHIFT = 5'h04,
    ST_PROG  = 5'h08,
    ST_READY = 5'h10
  } state_t;
endpackage : eeprom_cmd_pkg

// ---- dv/eeprom_host.sv ----
// host model that drives the serial command pins of the eeprom block
// assumes the bench calls its tasks at core clock falling edges
`timescale 1ns/10ps
module eeprom_host (
  // core clock
  input  wire logic clock,
  // serial pins
  output logic      chip_select,
  output logic      serial_clock,
  output logic      serial_data_in
);
  int slow = 6;  // core cycles per serial half period, 6 gives 24 ns

  // select low and serial clock still at power-up and between frames
  initial begin
    chip_select    = 1'b0;
    serial_clock   = 1'b0;
    serial_data_in = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic half();
    repeat (slow) @(negedge clock);
  endtask : half

  // data changes only while the serial clock is low
  task automatic pulse(input logic d);
    serial_data_in = d;
    half();
    serial_clock = 1'b1;
    half();
    serial_clock = 1'b0;
  endtask : pulse

  // dummy clocks, start bit, payload msb first, then select low to execute
  task automatic frame(input logic [31:0] bits, input int n, input int dum);
    chip_select = 1'b1;
    half();
    repeat (dum) pulse(1'b0);
    pulse(1'b1);
    for (int i = n - 1; i >= 0; i--) pulse(bits[i]);
    serial_data_in = 1'b0;
    half();
    chip_select = 1'b0;
    half();
  endtask : frame

  // clocks with data high while deselected, must start nothing
  task automatic noise(input int n);
    repeat (n) pulse(1'b1);
    serial_data_in = 1'b0;
  endtask : noise

  task automatic select(input logic s);
    @(negedge clock);
    chip_select = s;
  endtask : select
endmodule : eeprom_host

// ---- dv/tb_serial_eeprom_write_protect_cmds.sv ----
// self-checking bench for the eeprom write command block
// assumes the host model drives the pins; a reference array lives here
`timescale 1ns/10ps
module tb_serial_eeprom_write_protect_cmds;
  localparam int PROG = 50;  // short programming time keeps the run brief
  logic        clock, reset, supply_low, chip_select, serial_clock, serial_data_in;
  logic        data_out, data_out_oe, program_enabled, busy, saw_busy, en_m;
  logic [5:0]  peek_addr;
  logic [15:0] peek_data, lfsr_q, r;
  logic [15:0] mem_m [64];
  int          err_count, n_tests;

  // core clock, 4 ns
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  eeprom_cmd #(.PROG_CYCLES(PROG)) dut (
    .clock(clock), .reset(reset), .chip_select(chip_select),
    .serial_clock(serial_clock), .serial_data_in(serial_data_in),
    .data_out(data_out), .data_out_oe(data_out_oe), .supply_low(supply_low),
    .program_enabled(program_enabled), .busy(busy),
    .peek_addr(peek_addr), .peek_data(peek_data));
  eeprom_host host (.clock(clock), .chip_select(chip_select),
    .serial_clock(serial_clock), .serial_data_in(serial_data_in));

  // remember whether any programming period started
  always @(posedge clock) if (busy === 1'b1) saw_busy <= 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction : rnd

  // a write-class command programs only when enabled and exactly counted
  function automatic logic progs(input logic [1:0] opc, input logic [5:0] a, input int e);
    return en_m && e == 0 && (opc != eeprom_cmd_pkg::OP_EXT
      || a[5:4] == eeprom_cmd_pkg::SUB_ALLW || a[5:4] == eeprom_cmd_pkg::SUB_ALLE);
  endfunction : progs

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  // bounded wait for the programming period to close
  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < PROG + 20) begin
      @(negedge clock);
      k++;
    end
    if (k >= PROG + 20) begin
      err_count++;
      $display("MISMATCH at %0t: busy got %h expected %h", $time, busy, 1'b0);
      test_done();
    end else begin
      repeat (4) @(negedge clock);
    end
  endtask : wait_idle

  task automatic sweep();
    for (int i = 0; i < 64; i++) begin
      peek_addr = i[5:0];
      @(negedge clock);
      chk(peek_data, mem_m[i]);
    end
  endtask : sweep

  // send one command, e clocks extra or missing, optional status poll
  task automatic op(input logic [1:0] opc, input logic [5:0] a, input logic [15:0] d,
                    input int e, input bit vfy);
    logic        hasd, prog;
    logic [31:0] full;
    hasd = opc == eeprom_cmd_pkg::OP_WRITE
      || (opc == eeprom_cmd_pkg::OP_EXT && a[5:4] == eeprom_cmd_pkg::SUB_ALLW);
    full = hasd ? {8'h00, opc, a, d} : {24'h00_0000, opc, a};
    prog = progs(opc, a, e);
    saw_busy = 1'b0;
    host.frame(e >= 0 ? full << e : full >> -e, (hasd ? 24 : 8) + e, rnd() % 3);
    if (vfy) begin
      host.select(1'b1);
      repeat (5) @(negedge clock);
      chk({data_out_oe, data_out}, 2'b10);
      wait_idle();
      chk({data_out_oe, data_out}, 2'b11);
      host.select(1'b0);
    end
    wait_idle();
    chk(saw_busy, prog);
    if (opc == eeprom_cmd_pkg::OP_EXT && e <= 0 && e >= -4) begin
      if (a[5:4] == eeprom_cmd_pkg::SUB_ON) en_m = 1'b1;
      if (a[5:4] == eeprom_cmd_pkg::SUB_OFF) en_m = 1'b0;
    end
    if (prog) begin
      for (int i = 0; i < 64; i++) begin
        if (opc == eeprom_cmd_pkg::OP_EXT || i == a) begin
          mem_m[i] = hasd ? d : eeprom_cmd_pkg::ERASED_WORD;
        end
      end
    end
    chk(program_enabled, en_m);
  endtask : op

  ////////////////////////////////////////////////////////////////////////////
  // main sequence; pins idle during the two reset cycles, so the synchronisers settle
  initial begin
    reset = 1'b1;
    supply_low = 1'b0;
    peek_addr = 6'h00;
    lfsr_q = 16'h2DED;
    err_count = 0;
    n_tests = 0;
    en_m = 1'b0;
    saw_busy = 1'b0;
    repeat (2) @(negedge clock);
    reset = 1'b0;
    @(negedge clock);
    chk(program_enabled, 1'b0);
    op(eeprom_cmd_pkg::OP_WRITE, 6'h05, rnd(), 0, 0);
    op(eeprom_cmd_pkg::OP_EXT, {eeprom_cmd_pkg::SUB_ON, 4'h0}, 16'h0000, -4, 0);
    op(eeprom_cmd_pkg::OP_EXT, {eeprom_cmd_pkg::SUB_ALLE, 4'h9}, 16'h0000, 0, 0);
    sweep();
    $display("test array erase finished");
    // few addresses so words get rewritten without an erase between
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      op(eeprom_cmd_pkg::OP_WRITE, {3'h0, r[2:0]}, rnd(), 0, i == 3);
    end
    op(eeprom_cmd_pkg::OP_ERASE, 6'h03, 16'h0000, 0, 0);
    sweep();
    $display("test word write finished");
    for (int e = -1; e <= 1; e += 2) begin
      op(eeprom_cmd_pkg::OP_WRITE, 6'h01, 16'h0000, e, 0);
      op(eeprom_cmd_pkg::OP_ERASE, 6'h02, 16'h0000, e, 0);
      op(eeprom_cmd_pkg::OP_EXT, {eeprom_cmd_pkg::SUB_ALLW, 4'h0}, 16'h1234, e, 0);
      op(eeprom_cmd_pkg::OP_EXT, {eeprom_cmd_pkg::SUB_ALLE, 4'h0}, 16'h0000, e, 0);
    end
    sweep();
    r = rnd();
    op(eeprom_cmd_pkg::OP_EXT, {eeprom_cmd_pkg::SUB_ALLW, r[3:0]}, rnd(), 0, 1);
    sweep();
    saw_busy = 1'b0;
    host.noise(10);
    repeat (8) @(negedge clock);
    chk(saw_busy, 1'b0);
    op(eeprom_cmd_pkg::OP_EXT, {eeprom_cmd_pkg::SUB_OFF, 4'h0}, 16'h0000, 0, 0);
    op(eeprom_cmd_pkg::OP_ERASE, 6'h07, 16'h0000, 0, 0);
    $display("test protection finished");
    // low supply cancels a running write and turns programming off
    op(eeprom_cmd_pkg::OP_EXT, {eeprom_cmd_pkg::SUB_ON, 4'h0}, 16'h0000, -2, 0);
    host.frame({8'h00, eeprom_cmd_pkg::OP_WRITE, 6'h04, 16'h0000}, 24, 0);
    supply_low = 1'b1;
    repeat (6) @(negedge clock);
    supply_low = 1'b0;
    repeat (4) @(negedge clock);
    en_m = 1'b0;
    chk(busy, 1'b0);
    chk(program_enabled, 1'b0);
    op(eeprom_cmd_pkg::OP_WRITE, 6'h04, rnd(), 0, 0);
    op(eeprom_cmd_pkg::OP_EXT, {eeprom_cmd_pkg::SUB_ON, 4'h0}, 16'h0000, 0, 0);
    // a different word, so the sweep still sees the cancelled word untouched
    op(eeprom_cmd_pkg::OP_WRITE, 6'h06, rnd(), 0, 0);
    sweep();
    $display("test low supply finished");
    test_done();
  end
endmodule : tb_serial_eeprom_write_protect_cmds
